// ### gfsm_top.sv
// Function-select mux for general-purpose pins 1 and 2, AXI4-Lite slave.
// Assumes internal sources on the same clock and pad levels asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "gfsm_params.svh"

//
// Overview of operation
// - Pin 1 pull-up on when its pull-up bit set and pin is digital input.
// - Pin 2 pull-up on when its pull-up bit set and pin is digital input.
// - Bits 7:6 of each config register set the pin drive strength.
// - Pin 1 code 00000 outputs the inverted power-on reset.
// - Pin 2 code 00000 outputs the microcontroller clock.
// - Code 00001 drives high once the wake-up timer has expired.
// - Code 00010 drives high while battery is below threshold.
// - Code 00011 makes the pin a direct digital input, undriven.
// - Codes 00100-00110 are interrupt inputs: falling, rising, any edge.
// - Code 00111 routes the pin to the ADC, driver off.
// - Code 01010 drives the software direct-I/O level.
// - Code 01110 presents the reference voltage on the pin.
// - Code 01111 outputs the received-data bit clock.
// - Code 10001 takes an external retransmission request input.
// - Codes 10100-10110 output rx data, rx state, FIFO almost full.
// - Codes 10111 and 11000 output antenna switch controls 1 and 2.
// - Codes 11001 and 11010 output valid and invalid preamble detect.
// - Code 11011 outputs sync word detected.
// - Code 11100 outputs clear channel, 11101 high, others low.
// - Reserved codes are not programmed by software; behaviour undefined.
// - Direct output follows its I/O bit; direct input reads pin level.
// - Interrupt status of each pin is readable in the port register.
module gfsm_top
    import gfsm_pkg::*;
#(
    parameter int ADDR_WIDTH = `GFSM_AXI_ADDR_WIDTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic porActive,
    input wire logic mcuClock,
    input wire logic wakeupTimerExpired,
    input wire logic lowBattery,
    input wire logic rxDataClock,
    input wire logic rxData,
    input wire logic rxState,
    input wire logic rxFifoAlmostFull,
    input wire logic antenna1Switch,
    input wire logic antenna2Switch,
    input wire logic preambleValid,
    input wire logic preambleInvalid,
    input wire logic syncWordDetected,
    input wire logic clearChannel,
    input wire logic [1:0] gpioIn,
    output logic [1:0] gpioOut,
    output logic [1:0] gpioOe,
    output logic [1:0] gpioPullupEn,
    output logic [3:0] gpioDriveStrength,
    output logic [1:0] gpioAdcEn,
    output logic [1:0] gpioVrefEn,
    output logic [1:0] extIrqPulse,
    output logic [1:0] extIrqPending,
    output logic [1:0] retxRequest
);
    generate
        if (ADDR_WIDTH < 6) begin : gen_check
            $error("gfsm_top needs at least six address bits");
        end
    endgenerate

    localparam logic [ADDR_WIDTH-1:0] PIN1_ADDR =
        ADDR_WIDTH'({`GFSM_IDX_PIN1_CFG, 2'h0});
    localparam logic [ADDR_WIDTH-1:0] PIN2_ADDR =
        ADDR_WIDTH'({`GFSM_IDX_PIN2_CFG, 2'h0});
    localparam logic [ADDR_WIDTH-1:0] PORT_ADDR =
        ADDR_WIDTH'({`GFSM_IDX_PORT_CFG, 2'h0});

    gfsm_wr_state_type wrState_q;
    gfsm_rd_state_type rdState_q;
    logic awHave_q;
    logic wHave_q;
    logic [ADDR_WIDTH-1:0] awAddr_q;
    logic [7:0] wData_q;
    logic wLane_q;
    logic [1:0] bResp_q;
    logic [31:0] rData_q;
    logic [1:0] rResp_q;
    logic wrFire;
    logic [2:0] wrSel;
    logic [7:0] cfgAll [2];
    logic [1:0] dioRead;
    logic [1:0] irqSts;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic [2:0] decode(input logic [ADDR_WIDTH-1:0] a);
        decode = '0;
        decode[0] = a[ADDR_WIDTH-1:2] == PIN1_ADDR[ADDR_WIDTH-1:2];
        decode[1] = a[ADDR_WIDTH-1:2] == PIN2_ADDR[ADDR_WIDTH-1:2];
        decode[2] = a[ADDR_WIDTH-1:2] == PORT_ADDR[ADDR_WIDTH-1:2];
    endfunction

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign s_axi_awready = (wrState_q == GFSM_WR_COLLECT) && !awHave_q;
    assign s_axi_wready = (wrState_q == GFSM_WR_COLLECT) && !wHave_q;
    assign s_axi_bvalid = wrState_q == GFSM_WR_RESP;
    assign s_axi_bresp = bResp_q;
    assign wrFire = (wrState_q == GFSM_WR_COLLECT) && awHave_q && wHave_q;
    assign wrSel = wrFire && wLane_q ? decode(awAddr_q) : 3'h0;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awHave_q <= 1'b0;
            awAddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (wrFire) begin
            awHave_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wHave_q <= 1'b0;
            wData_q <= 8'h00;
            wLane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
        end else if (wrFire) begin
            wHave_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrState_q <= GFSM_WR_COLLECT;
            bResp_q <= `GFSM_RESP_OKAY;
        end else begin
            case (wrState_q)
                GFSM_WR_COLLECT: begin
                    if (wrFire) begin
                        wrState_q <= GFSM_WR_RESP;
                        bResp_q <= (decode(awAddr_q) != 3'h0) ?
                            `GFSM_RESP_OKAY : `GFSM_RESP_SLVERR;
                    end
                end
                GFSM_WR_RESP: begin
                    if (s_axi_bready) begin
                        wrState_q <= GFSM_WR_COLLECT;
                    end
                end
                default: begin
                    wrState_q <= GFSM_WR_COLLECT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = rdState_q == GFSM_RD_IDLE;
    assign s_axi_rvalid = rdState_q == GFSM_RD_DATA;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdState_q <= GFSM_RD_IDLE;
            rData_q <= 32'h0000_0000;
            rResp_q <= `GFSM_RESP_OKAY;
        end else begin
            case (rdState_q)
                GFSM_RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdState_q <= GFSM_RD_DATA;
                        rResp_q <= `GFSM_RESP_OKAY;
                        rData_q <= 32'h0000_0000;
                        case (decode(s_axi_araddr))
                            3'h1: rData_q[7:0] <= cfgAll[0];
                            3'h2: rData_q[7:0] <= cfgAll[1];
                            3'h4: begin
                                rData_q[`GFSM_PORT_DIO_LSB+:2] <= dioRead;
                                rData_q[`GFSM_PORT_STS_LSB+:2] <= irqSts;
                            end
                            default: rResp_q <= `GFSM_RESP_SLVERR;
                        endcase
                    end
                end
                GFSM_RD_DATA: begin
                    if (s_axi_rready) begin
                        rdState_q <= GFSM_RD_IDLE;
                    end
                end
                default: begin
                    rdState_q <= GFSM_RD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-pin configuration, mux and input events
    // ------------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : gen_pin
            logic [7:0] cfg_q;
            logic dio_q;
            logic sts_q;
            logic out_q;
            logic oe_q;
            logic pup_q;
            logic [1:0] drv_q;
            logic adc_q;
            logic vref_q;
            logic irq_q;
            logic retx_q;
            logic [4:0] code;
            logic level;
            logic rise;
            logic fall;
            logic isDin;
            logic isAnalog;
            logic isVref;
            logic value;
            logic irqEvent;
            logic specialSrc;

            assign code = cfg_q[`GFSM_FUNC_MSB:`GFSM_FUNC_LSB];
            if (p == 0) begin : gen_src1
                assign specialSrc = ~porActive;
            end else begin : gen_src2
                assign specialSrc = mcuClock;
            end

            gfsm_pin_sync #(
                .STAGES(`GFSM_SYNC_STAGES)
            ) u_sync (
                .clock(clock),
                .rst_n(rst_n),
                .pinAsync(gpioIn[p]),
                .level(level),
                .rise(rise),
                .fall(fall)
            );

            assign isDin = code == `GFSM_FN_DIN || code == `GFSM_FN_RETX ||
                code == `GFSM_FN_IRQ_FALL || code == `GFSM_FN_IRQ_RISE ||
                code == `GFSM_FN_IRQ_ANY;
            assign isAnalog = code == `GFSM_FN_ADC;
            assign isVref = code == `GFSM_FN_VREF;
            assign irqEvent = (code == `GFSM_FN_IRQ_FALL && fall) ||
                (code == `GFSM_FN_IRQ_RISE && rise) ||
                (code == `GFSM_FN_IRQ_ANY && (rise || fall));

            always_comb begin
                case (code)
                    `GFSM_FN_SPECIAL: value = specialSrc;
                    `GFSM_FN_WAKEUP: value = wakeupTimerExpired;
                    `GFSM_FN_LOWBAT: value = lowBattery;
                    `GFSM_FN_DOUT: value = dio_q;
                    `GFSM_FN_RXCLK: value = rxDataClock;
                    `GFSM_FN_RXDATA: value = rxData;
                    `GFSM_FN_RXSTATE: value = rxState;
                    `GFSM_FN_FIFO_AF: value = rxFifoAlmostFull;
                    `GFSM_FN_ANT1: value = antenna1Switch;
                    `GFSM_FN_ANT2: value = antenna2Switch;
                    `GFSM_FN_PRE_OK: value = preambleValid;
                    `GFSM_FN_PRE_BAD: value = preambleInvalid;
                    `GFSM_FN_SYNC: value = syncWordDetected;
                    `GFSM_FN_CCA: value = clearChannel;
                    `GFSM_FN_VDD: value = 1'b1;
                    default: value = 1'b0;
                endcase
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    cfg_q <= `GFSM_CFG_RESET;
                end else if (wrSel[p]) begin
                    cfg_q <= wData_q;
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    dio_q <= `GFSM_DIO_RESET;
                end else if (wrSel[2]) begin
                    dio_q <= wData_q[`GFSM_PORT_DIO_LSB+p];
                end
            end

            // Sticky status, write one to clear; a new event wins
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    sts_q <= 1'b0;
                end else if (irqEvent) begin
                    sts_q <= 1'b1;
                end else if (wrSel[2] && wData_q[`GFSM_PORT_STS_LSB+p]) begin
                    sts_q <= 1'b0;
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    out_q <= 1'b0;
                    oe_q <= 1'b0;
                    pup_q <= 1'b0;
                    drv_q <= 2'h0;
                    adc_q <= 1'b0;
                    vref_q <= 1'b0;
                end else begin
                    out_q <= value;
                    oe_q <= !(isDin || isAnalog || isVref);
                    pup_q <= cfg_q[`GFSM_PUP_BIT] && isDin;
                    drv_q <= cfg_q[`GFSM_DRV_MSB:`GFSM_DRV_LSB];
                    adc_q <= isAnalog;
                    vref_q <= isVref;
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    irq_q <= 1'b0;
                    retx_q <= 1'b0;
                end else begin
                    irq_q <= irqEvent;
                    retx_q <= code == `GFSM_FN_RETX && rise;
                end
            end

            assign cfgAll[p] = cfg_q;
            assign dioRead[p] = code == `GFSM_FN_DIN ? level : dio_q;
            assign irqSts[p] = sts_q;
            assign gpioOut[p] = out_q;
            assign gpioOe[p] = oe_q;
            assign gpioPullupEn[p] = pup_q;
            assign gpioDriveStrength[2*p+:2] = drv_q;
            assign gpioAdcEn[p] = adc_q;
            assign gpioVrefEn[p] = vref_q;
            assign extIrqPulse[p] = irq_q;
            assign extIrqPending[p] = sts_q;
            assign retxRequest[p] = retx_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ### gfsm_params.svh
// Constants of the function-select mux for pins 1 and 2.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef GFSM_PARAMS_SVH
`define GFSM_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus and synchroniser
// ----------------------------------------------------------------------
`define GFSM_AXI_ADDR_WIDTH 8
`define GFSM_SYNC_STAGES 2
`define GFSM_RESP_OKAY 2'h0
`define GFSM_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define GFSM_IDX_PIN1_CFG 8'h0c
`define GFSM_IDX_PIN2_CFG 8'h0d
`define GFSM_IDX_PORT_CFG 8'h0e
`define GFSM_CFG_RESET 8'h00
`define GFSM_DIO_RESET 1'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GFSM_DRV_MSB 7
`define GFSM_DRV_LSB 6
`define GFSM_PUP_BIT 5
`define GFSM_FUNC_MSB 4
`define GFSM_FUNC_LSB 0
`define GFSM_PORT_DIO_LSB 1
`define GFSM_PORT_STS_LSB 5

// ----------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------
`define GFSM_FN_SPECIAL 5'h00
`define GFSM_FN_WAKEUP 5'h01
`define GFSM_FN_LOWBAT 5'h02
`define GFSM_FN_DIN 5'h03
`define GFSM_FN_IRQ_FALL 5'h04
`define GFSM_FN_IRQ_RISE 5'h05
`define GFSM_FN_IRQ_ANY 5'h06
`define GFSM_FN_ADC 5'h07
`define GFSM_FN_DOUT 5'h0a
`define GFSM_FN_VREF 5'h0e
`define GFSM_FN_RXCLK 5'h0f
`define GFSM_FN_RETX 5'h11
`define GFSM_FN_RXDATA 5'h14
`define GFSM_FN_RXSTATE 5'h15
`define GFSM_FN_FIFO_AF 5'h16
`define GFSM_FN_ANT1 5'h17
`define GFSM_FN_ANT2 5'h18
`define GFSM_FN_PRE_OK 5'h19
`define GFSM_FN_PRE_BAD 5'h1a
`define GFSM_FN_SYNC 5'h1b
`define GFSM_FN_CCA 5'h1c
`define GFSM_FN_VDD 5'h1d

`endif

// ### gfsm_pkg.sv
// Types shared by the function-select mux files.
// Assumes the constants header sits in the same folder.
package gfsm_pkg;
    typedef enum logic [1:0] {
        GFSM_WR_COLLECT = 2'h1,
        GFSM_WR_RESP = 2'h2
    } gfsm_wr_state_type;

    typedef enum logic [1:0] {
        GFSM_RD_IDLE = 2'h1,
        GFSM_RD_DATA = 2'h2
    } gfsm_rd_state_type;
endpackage

// ### gfsm_pin_sync.sv
// Pin input synchroniser with edge detection.
// Assumes an asynchronous pad level and a single system clock.
`timescale 1ns/100ps
`default_nettype none
`include "gfsm_params.svh"

module gfsm_pin_sync
    import gfsm_pkg::*;
#(
    parameter int STAGES = `GFSM_SYNC_STAGES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pinAsync,
    output logic level,
    output logic rise,
    output logic fall
);
    generate
        if (STAGES < 2) begin : gen_check
            $error("gfsm_pin_sync needs at least two stages");
        end
    endgenerate

    logic [STAGES-1:0] chain_q;
    logic prev_q;

    // ------------------------------------------------------------------
    // Metastability chain; first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], pinAsync};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= chain_q[STAGES-1];
        end
    end

    assign level = chain_q[STAGES-1];
    assign rise = chain_q[STAGES-1] & ~prev_q;
    assign fall = ~chain_q[STAGES-1] & prev_q;
endmodule
`default_nettype wire

// ### gfsm_top_asserts.sv
// Concurrent checks on the ports of the function-select mux.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module gfsm_top_asserts
    import gfsm_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] gpioIn,
    input wire logic [1:0] gpioOe,
    input wire logic [1:0] gpioPullupEn,
    input wire logic [1:0] gpioAdcEn,
    input wire logic [1:0] gpioVrefEn,
    input wire logic [1:0] extIrqPulse,
    input wire logic [1:0] extIrqPending,
    input wire logic [1:0] retxRequest
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_pullup_pin1: assert property (gpioPullupEn[0] |-> !gpioOe[0])
        else $error("pin 1 pull-up on a driven pin");
    a_pullup_pin2: assert property (gpioPullupEn[1] |-> !gpioOe[1])
        else $error("pin 2 pull-up on a driven pin");
    a_adc_undriven: assert property ((gpioAdcEn & gpioOe) == 2'h0)
        else $error("analog pin driven");
    a_vref_alone: assert property
        ((gpioVrefEn & (gpioOe | gpioPullupEn | gpioAdcEn)) == 2'h0)
        else $error("reference pin also driven");
    a_irq_latency: assert property (extIrqPulse[0] |->
        $past(gpioIn[0], 3) != $past(gpioIn[0], 4))
        else $error("interrupt without synchronised edge");
    a_irq_status: assert property ((extIrqPulse & ~extIrqPending) == 2'h0)
        else $error("interrupt pulse without status");
    a_retx_rise: assert property (retxRequest[1] |->
        $past(gpioIn[1], 3) && !$past(gpioIn[1], 4))
        else $error("retransmit without rising edge");
    a_input_undriven: assert property
        (((extIrqPulse | retxRequest) & gpioOe) == 2'h0)
        else $error("input function pin driven");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read data late or wide");

    c_irq_seen: cover property (extIrqPulse[0]);
    c_retx_seen: cover property (retxRequest[1]);
    c_adc_seen: cover property (gpioAdcEn != 2'h0);
endmodule

bind gfsm_top gfsm_top_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_gfsm_top_asserts (
    .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .gpioIn, .gpioOe, .gpioPullupEn,
    .gpioAdcEn, .gpioVrefEn, .extIrqPulse, .extIrqPending, .retxRequest);
`default_nettype wire

// ### gfsm_pad_model.sv
// Board model of pins 1 and 2: pad level from all drivers.
// Assumes the bench sets an external driver and its enable per pin.
`timescale 1ns/100ps
`default_nettype none
module gfsm_pad_model
    import gfsm_pkg::*;
(
    input wire logic clock,
    input wire logic [1:0] gpioOut,
    input wire logic [1:0] gpioOe,
    input wire logic [1:0] gpioPullupEn,
    input wire logic [1:0] extDrive,
    input wire logic [1:0] extEnable,
    output logic [1:0] gpioIn
);
    logic [1:0] lastQ = 2'h0;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (gpioOe[i]) gpioIn[i] = gpioOut[i];
            else if (extEnable[i]) gpioIn[i] = extDrive[i];
            else if (gpioPullupEn[i]) gpioIn[i] = 1'b1;
            else gpioIn[i] = ~lastQ[i];
        end
    end
    // Floating pad toggles so it never reads as a steady level
    always @(posedge clock) lastQ <= gpioIn;
endmodule
`default_nettype wire

// ### test_gpio_function_select_mux.sv
// Self-checking bench for the pin function-select mux.
// Assumes the pad model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "gfsm_params.svh"
module test_gpio_function_select_mux
    import gfsm_pkg::*;
;
    localparam logic [7:0] A_CFG1 = `GFSM_IDX_PIN1_CFG << 2;
    localparam logic [7:0] A_PORT = `GFSM_IDX_PORT_CFG << 2;
    logic clock = 0, rst_n = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    logic [13:0] src = 0;
    logic [1:0] extD = 0, extEn = 2'h3;
    wire logic [1:0] gpioIn, gpioOut, gpioOe, gpioPullupEn, gpioAdcEn;
    wire logic [1:0] gpioVrefEn, extIrqPulse, extIrqPending, retxRequest;
    wire logic [3:0] gpioDriveStrength;
    int err_count = 0, n_tests = 0, cyc = 0, irqCnt = 0, retxCnt = 0;
    // Rows: code in [8:4], routed source in [3:0] (14 high, 15 low)
    logic [11:0] rows [17] = '{12'h000, 12'h012, 12'h023, 12'h0f4,
        12'h145, 12'h156, 12'h167, 12'h178, 12'h189, 12'h19a, 12'h1ab,
        12'h1bc, 12'h1cd, 12'h1de, 12'h1ef, 12'h1ff, 12'h0af};

    gfsm_top u_gfsm_top (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .porActive(src[0]), .mcuClock(src[1]), .wakeupTimerExpired(src[2]),
        .lowBattery(src[3]), .rxDataClock(src[4]), .rxData(src[5]),
        .rxState(src[6]), .rxFifoAlmostFull(src[7]),
        .antenna1Switch(src[8]), .antenna2Switch(src[9]),
        .preambleValid(src[10]), .preambleInvalid(src[11]),
        .syncWordDetected(src[12]), .clearChannel(src[13]), .gpioIn,
        .gpioOut, .gpioOe, .gpioPullupEn, .gpioDriveStrength, .gpioAdcEn,
        .gpioVrefEn, .extIrqPulse, .extIrqPending, .retxRequest);
    gfsm_pad_model u_gfsm_pad_model (.clock, .gpioOut, .gpioOe,
        .gpioPullupEn, .extDrive(extD), .extEnable(extEn), .gpioIn);

    initial forever #10 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (extIrqPulse[0]) irqCnt++;
        if (retxRequest[1]) retxCnt++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic waitN(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic cfg(input int p, input logic [7:0] v);
        logic [1:0] r;
        wr(A_CFG1 + 8'(4 * p), v, r);
        chk("cfg bresp", `GFSM_RESP_OKAY, r);
        waitN(2);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int sel, ex;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd(A_CFG1, d, r);
        chk("cfg1 reset", 32'h0, d);
        chk("oe reset", 2'h3, gpioOe);
        chk("out reset", 2'h1, gpioOut);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 17; i++) begin
                sel = (rows[i][8:4] == 5'h00) ? p : rows[i][3:0];
                cfg(p, {i[1:0], 1'b0, rows[i][8:4]});
                chk("drive", i[1:0], gpioDriveStrength[2*p +: 2]);
                for (int v = 0; v < 2; v++) begin
                    src <= v ? (14'h1 << sel) : ~(14'h1 << sel);
                    waitN(2);
                    ex = (sel < 14) ? (v ^ (p == 0 && sel == 0)) : (sel == 14);
                    chk("out", ex[0], gpioOut[p]);
                    chk("oe", 1'b1, gpioOe[p]);
                end
            end
        end
        for (int p = 0; p < 2; p++) begin
            cfg(p, `GFSM_FN_DOUT);
            wr(A_PORT, 8'h02 << p, r);
            waitN(2);
            chk("dout", 1'b1, gpioOut[p]);
            extEn[p] <= 1'b0;
            cfg(p, 8'h23);
            chk("pullup", 1'b1, gpioPullupEn[p]);
            chk("oe din", 1'b0, gpioOe[p]);
            rd(A_PORT, d, r);
            chk("din float", 1'b1, d[p+1]);
            extD[p] <= 1'b0;
            extEn[p] <= 1'b1;
            waitN(4);
            rd(A_PORT, d, r);
            chk("din low", 1'b0, d[p+1]);
            cfg(p, 8'h27);
            chk("adc", 3'h2, {gpioPullupEn[p], gpioAdcEn[p], gpioOe[p]});
            cfg(p, `GFSM_FN_VREF);
            chk("vref", 2'h2, {gpioVrefEn[p], gpioOe[p]});
        end
        for (int c = 4; c < 7; c++) begin
            cfg(0, c[7:0]);
            waitN(4);
            sel = irqCnt;
            extD[0] <= 1'b1;
            waitN(6);
            chk("irq rise", c != 4, irqCnt - sel);
            extD[0] <= 1'b0;
            waitN(6);
            chk("irq all", (c != 4) + (c != 5), irqCnt - sel);
            rd(A_PORT, d, r);
            chk("pending", 2'h3, {extIrqPending[0], d[5]});
            wr(A_PORT, 8'h20, r);
            rd(A_PORT, d, r);
            chk("cleared", 2'h0, {extIrqPending[0], d[5]});
        end
        cfg(1, `GFSM_FN_RETX);
        rd(A_CFG1 + 8'h04, d, r);
        chk("cfg2 read", 32'h11, d);
        sel = retxCnt;
        extD[1] <= 1'b1;
        waitN(6);
        extD[1] <= 1'b0;
        waitN(6);
        chk("retx", 1, retxCnt - sel);
        wr(8'h3c, 8'hff, r);
        chk("bresp unmapped", `GFSM_RESP_SLVERR, r);
        rd(8'h3c, d, r);
        chk("rresp unmapped", `GFSM_RESP_SLVERR, r);
        chk("rdata unmapped", 32'h0, d);
        give_verdict();
    end
endmodule
`default_nettype wire
